// ---- include/srx_pkg.sv ----
package srx_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_GAP = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  // status register fields
  localparam int ST_CHAR_GAP_TIMEOUT_FLAG = 26;
  localparam int ST_CNT_LO = 20;
  localparam int ST_MODEM_LO = 16;
  localparam int ST_BRK = 15;
  localparam int ST_FE = 14;
  localparam int ST_PE = 13;
  localparam int ST_OVR = 12;
  localparam int ST_RX_READY_FLAG = 11;
  localparam int ST_RBC = 9;
  // control register fields
  localparam int CTL_RX_READY_FLAG_IE = 0;
  localparam int CTL_DMA = 1;
  localparam int CTL_GAP_EN = 2;
  // descriptor status copies
  localparam int DSC_CHAR_GAP_TIMEOUT_FLAG = 10;
  localparam int DSC_BRK = 3;
  localparam int DSC_FE = 2;
  localparam int DSC_PE = 1;
  localparam int DSC_OVR = 0;
  // widths and reset values
  localparam int CTRL_W = 3;
  localparam int GAP_W = 16;
  localparam int FIFO_AW = 3;
  localparam int ENTRY_W = 34;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [GAP_W-1:0] GAP_RST = 16'h0010;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- include/srx_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface srx_fifo_if;
  // entry: {valid byte count, 32-bit word}
  logic push;
  logic [srx_pkg::ENTRY_W-1:0] wdata;
  logic full;
  logic pop;
  logic [srx_pkg::ENTRY_W-1:0] q;
  logic head_vld;
  modport owner (output push, output wdata, output pop,
    input full, input q, input head_vld);
  modport store (input push, input wdata, input pop,
    output full, output q, output head_vld);
endinterface
`default_nettype wire

// ---- src/srx_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module srx_fifo (
  input wire logic aclk,
  input wire logic aresetn,
  srx_fifo_if.store f
);
  localparam int AW = srx_pkg::FIFO_AW;
  localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

  logic [srx_pkg::ENTRY_W-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] cnt;
  wire do_push = f.push && (cnt != DEPTH);
  wire do_pop = f.pop && (cnt != '0);
  wire [AW-1:0] next_rptr = do_pop ? rptr + 1'b1 : rptr;
  wire [AW:0] next_cnt = cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  // forward a word written into the slot that becomes the head
  wire fwd = do_push && (wptr == next_rptr);

  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wptr] <= f.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr <= '0;
      rptr <= '0;
      cnt <= '0;
      f.q <= '0;
      f.head_vld <= 1'b0;
      f.full <= 1'b0;
    end else begin
      wptr <= do_push ? wptr + 1'b1 : wptr;
      rptr <= next_rptr;
      cnt <= next_cnt;
      f.q <= fwd ? f.wdata : mem[next_rptr];
      f.head_vld <= (next_cnt != '0);
      f.full <= (next_cnt == DEPTH);
    end
  end
endmodule
`default_nettype wire

// ---- src/srx_status.sv ----
// Overview of operation
// R1 - gap timeout sets gap flag, closes buffer
// R2 - DMA copies gap flag to descriptor bit 10
// R3 - status bits 25:22 always read zero
// R4 - byte count: 00 full,01,10 half,11 three
// R5 - byte count meaningful only while ready set
// R6 - software reads byte count before data
// R7 - bytes packed by system byte order
// R8 - live DCD RI DSR CTS on 19..16
// R9 - break sets flag, closes, descriptor bit 3
// R10 - framing error sets flag, closes, bit 2
// R11 - parity error sets flag, closes, bit 1
// R12 - full FIFO: drop character, set overrun
// R13 - overrun closes buffer, descriptor bit 0
// R14 - software must not trust overrun status
// R15 - ready flag while FIFO holds data
// R16 - ready raises interrupt when enabled; the code raises it only outside DMA mode
// R17 - ready held low while buffer closed
// R18 - software writes one to clear closed
// R19 - DMA mode acknowledges closed by itself
// R20 - closed flag set on close, write-one clears
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module srx_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_break,
  input wire logic rx_framing_err,
  input wire logic rx_parity_err,
  input wire logic dcd_pin,
  input wire logic ri_pin,
  input wire logic dsr_pin,
  input wire logic cts_pin,
  output logic rx_ready_irq,
  output logic desc_stb,
  output logic [15:0] desc_status
);
  srx_fifo_if fq ();

  srx_fifo u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .f(fq.store)
  );

  // control and state registers
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [srx_pkg::CTRL_W-1:0] ctrl;
  logic [srx_pkg::GAP_W-1:0] gap_timeout;
  logic [srx_pkg::GAP_W-1:0] gap_cnt;
  logic buf_open;
  logic [31:0] pack_word;
  logic [1:0] pack_cnt;
  logic char_gap_timeout_flag;
  logic rx_break_flag;
  logic rx_framing_error_flag;
  logic rx_parity_error_flag;
  logic rx_overrun_flag;
  logic rx_buffer_closed_flag;
  logic [3:0] modem_meta;
  logic [3:0] modem_live;

  function automatic logic [31:0] put_byte(input logic [31:0] w,
    input logic [1:0] lane, input logic [7:0] b);
    logic [31:0] r;
    r = w;
    r[8*lane +: 8] = b;
    return r;
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  wire dma_mode = ctrl[srx_pkg::CTL_DMA];
  wire gap_en = ctrl[srx_pkg::CTL_GAP_EN];

  // write path: address and data are taken in either order
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_status = wr_go && (aw_addr == srx_pkg::ADDR_STATUS);
  wire wr_ctrl = wr_go && (aw_addr == srx_pkg::ADDR_CTRL);
  wire wr_gap = wr_go && (aw_addr == srx_pkg::ADDR_GAP);
  wire wr_data = wr_go && (aw_addr == srx_pkg::ADDR_DATA);
  wire wr_ok = wr_status || wr_ctrl || wr_gap || wr_data;
  wire [31:0] ctrl_new = wmask(32'(ctrl), w_data, w_strb);
  wire [31:0] gap_new = wmask(32'(gap_timeout), w_data, w_strb);

  // receive path
  wire rx_ready_flag = fq.head_vld && !rx_buffer_closed_flag; // R15 R17
  wire gap_hit = gap_en && buf_open && (gap_cnt >= gap_timeout); // R1
  wire [2:0] fill = 3'(pack_cnt) + 3'(rx_byte_valid);
  wire [31:0] word_in = rx_byte_valid ?
    put_byte(pack_word, pack_cnt, rx_byte) : pack_word; // R7
  wire err_close = rx_break || rx_framing_err || rx_parity_err;
  wire push_req = (fill == 3'd4) ||
    ((gap_hit || err_close) && (fill != 3'd0));
  wire ovr_evt = push_req && fq.full; // R12
  wire close_evt = gap_hit || err_close || ovr_evt; // R1 R9 R10 R11 R13

  // read path
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire rd_status = s_axi_araddr == srx_pkg::ADDR_STATUS;
  wire rd_ctrl = s_axi_araddr == srx_pkg::ADDR_CTRL;
  wire rd_gap = s_axi_araddr == srx_pkg::ADDR_GAP;
  wire rd_data = s_axi_araddr == srx_pkg::ADDR_DATA;
  wire rd_ok = rd_status || rd_ctrl || rd_gap || rd_data;
  // the data word is withheld while the buffer is closed
  wire rd_pop = ar_hs && rd_data && rx_ready_flag; // R17
  wire [1:0] fifo_valid_byte_count =
    fq.head_vld ? fq.q[33:32] : srx_pkg::CNT_RST; // R4 R5

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000; // R3
    status_word[srx_pkg::ST_CHAR_GAP_TIMEOUT_FLAG] = char_gap_timeout_flag;
    status_word[srx_pkg::ST_CNT_LO +: 2] = fifo_valid_byte_count; // R4
    status_word[srx_pkg::ST_MODEM_LO +: 4] = modem_live; // R8
    status_word[srx_pkg::ST_BRK] = rx_break_flag;
    status_word[srx_pkg::ST_FE] = rx_framing_error_flag;
    status_word[srx_pkg::ST_PE] = rx_parity_error_flag;
    status_word[srx_pkg::ST_OVR] = rx_overrun_flag;
    status_word[srx_pkg::ST_RX_READY_FLAG] = rx_ready_flag;
    status_word[srx_pkg::ST_RBC] = rx_buffer_closed_flag;
  end

  wire [31:0] rd_word = rd_status ? status_word :
    rd_ctrl ? 32'(ctrl) :
    rd_gap ? 32'(gap_timeout) :
    rd_pop ? fq.q[31:0] : 32'h0000_0000;

  // closed flag: software clears it, DMA mode acks it the cycle after
  wire sw_ack = wr_status && w_strb[1] &&
    w_data[srx_pkg::ST_RBC]; // R18 R20
  wire rbc_ack = sw_ack || (dma_mode && rx_buffer_closed_flag); // R19
  wire next_rbc = close_evt || (rx_buffer_closed_flag && !rbc_ack); // R20
  // error flags live until the closure they caused is acknowledged
  wire keep = !rbc_ack;

  assign fq.push = push_req && !fq.full; // R12
  assign fq.wdata = {fill[1:0], word_in}; // R4
  assign fq.pop = rd_pop;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modem_meta <= 4'h0;
      modem_live <= 4'h0;
    end else begin
      modem_meta <= {dcd_pin, ri_pin, dsr_pin, cts_pin};
      modem_live <= modem_meta; // R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srx_pkg::RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? srx_pkg::RESP_OKAY : srx_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= srx_pkg::RESP_OKAY;
    end else begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? srx_pkg::RESP_OKAY : srx_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= srx_pkg::CTRL_RST;
      gap_timeout <= srx_pkg::GAP_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= ctrl_new[srx_pkg::CTRL_W-1:0];
      end
      if (wr_gap) begin
        gap_timeout <= gap_new[srx_pkg::GAP_W-1:0];
      end
    end
  end

  // gap timer restarts on every byte; the buffer opens on the first one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_cnt <= '0;
      buf_open <= 1'b0;
    end else begin
      if (rx_byte_valid || close_evt) begin
        gap_cnt <= '0;
      end else if (buf_open && gap_cnt != '1) begin
        gap_cnt <= gap_cnt + 1'b1; // R1
      end
      buf_open <= !close_evt && (buf_open || rx_byte_valid);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pack_word <= 32'h0000_0000;
      pack_cnt <= 2'h0;
    end else if (push_req) begin
      // an overrun drops the word, the FIFO keeps its contents
      pack_word <= 32'h0000_0000; // R12
      pack_cnt <= 2'h0;
    end else begin
      pack_word <= word_in;
      pack_cnt <= fill[1:0];
    end
  end

  // a set in the same cycle as an acknowledge wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      char_gap_timeout_flag <= 1'b0;
      rx_break_flag <= 1'b0;
      rx_framing_error_flag <= 1'b0;
      rx_parity_error_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
      rx_buffer_closed_flag <= 1'b0;
    end else begin
      char_gap_timeout_flag <= gap_hit ||
        (char_gap_timeout_flag && keep); // R1
      rx_break_flag <= rx_break || (rx_break_flag && keep); // R9
      rx_framing_error_flag <= rx_framing_err ||
        (rx_framing_error_flag && keep); // R10
      rx_parity_error_flag <= rx_parity_err ||
        (rx_parity_error_flag && keep); // R11
      rx_overrun_flag <= ovr_evt || (rx_overrun_flag && keep); // R12
      rx_buffer_closed_flag <= next_rbc; // R20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ready_irq <= 1'b0;
      desc_stb <= 1'b0;
      desc_status <= 16'h0000;
    end else begin
      rx_ready_irq <= rx_ready_flag && !dma_mode &&
        ctrl[srx_pkg::CTL_RX_READY_FLAG_IE]; // R16
      desc_stb <= close_evt && dma_mode;
      if (close_evt && dma_mode) begin
        desc_status <= 16'h0000;
        desc_status[srx_pkg::DSC_CHAR_GAP_TIMEOUT_FLAG] <= gap_hit; // R2
        desc_status[srx_pkg::DSC_BRK] <= rx_break; // R9
        desc_status[srx_pkg::DSC_FE] <= rx_framing_err; // R10
        desc_status[srx_pkg::DSC_PE] <= rx_parity_err; // R11
        desc_status[srx_pkg::DSC_OVR] <= ovr_evt; // R13
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/srx_status_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module srx_status_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic desc_stb
);
  logic [7:0] rd_addr;
  wire logic st = s_axi_rvalid && rd_addr == srx_pkg::ADDR_STATUS;
  // address of the read in flight, the bus drops it after the handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_status_unused: assert property (st |-> s_axi_rdata[31:27] == 5'h0 &&
    s_axi_rdata[25:22] == 4'h0 && s_axi_rdata[10] == 1'b0)
    else $error("status unused bits not zero");
  a_ready_closed: assert property (st |-> !(s_axi_rdata[11] &&
    s_axi_rdata[9])) else $error("ready set while buffer closed");
  a_count_idle: assert property (st && !s_axi_rdata[11] &&
    !s_axi_rdata[9] |-> s_axi_rdata[21:20] == 2'h0)
    else $error("byte count nonzero with empty fifo");
  a_unmapped_err: assert property (s_axi_rvalid && rd_addr >= 8'h10 |->
    s_axi_rresp == srx_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken during response");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  cover property (st && s_axi_rdata[11]);
  cover property (s_axi_bvalid && s_axi_bresp == srx_pkg::RESP_SLVERR);
  cover property (desc_stb);
endmodule
`default_nettype wire

// ---- verification/srx_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module srx_line_model (
  input wire logic aclk,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_break,
  output logic rx_framing_err,
  output logic rx_parity_err
);
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    {rx_break, rx_framing_err, rx_parity_err} = 3'h0;
  end
  task automatic send(input logic [7:0] b);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge aclk);
    rx_byte_valid <= 1'b0;
    // no character: show junk, never the stale byte
    rx_byte <= ~b;
    @(posedge aclk);
  endtask
  // 0 break, 1 framing, 2 parity
  task automatic flag(input int k);
    {rx_break, rx_framing_err, rx_parity_err} <= 3'h4 >> k;
    @(posedge aclk);
    {rx_break, rx_framing_err, rx_parity_err} <= 3'h0;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ---- verification/test_serial_rx_status_fields.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_serial_rx_status_fields;
  localparam logic [7:0] A_ST = srx_pkg::ADDR_STATUS;
  localparam logic [7:0] A_CT = srx_pkg::ADDR_CTRL;
  localparam logic [7:0] A_DT = srx_pkg::ADDR_DATA;
  localparam logic [1:0] SLV = srx_pkg::RESP_SLVERR;
  localparam logic [31:0] CLS = 32'h0000_0200;
  localparam logic [31:0] RDY = 32'h0000_0800;
  localparam logic [31:0] ONE = 32'h0010_0000;
  logic [31:0] errs [3] = '{32'h0000_8000, 32'h0000_4000, 32'h0000_2000};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rx_byte_valid, rx_break, rx_framing_err, rx_parity_err;
  logic dcd_pin, ri_pin, dsr_pin, cts_pin, rx_ready_irq, desc_stb;
  logic [15:0] desc_status, seen_desc;
  int err_total, comparisons;
  srx_status uut (.*);
  srx_line_model line (.*);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) if (desc_stb) seen_desc <= desc_status;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = srx_pkg::RESP_OKAY, input int lag = 0);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // a lag keeps rready low so the answer has to wait
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == lag) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = srx_pkg::RESP_OKAY, input int lag = 0);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == lag) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {dcd_pin, ri_pin, dsr_pin, cts_pin} = 4'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_ST, 32'h0000_0000);
    rd(A_CT, 32'h0000_0000, srx_pkg::RESP_OKAY, 4);
    rd(srx_pkg::ADDR_GAP, 32'h0000_0010);
    for (int i = 0; i < 4; i++) begin
      {dcd_pin, ri_pin, dsr_pin, cts_pin} <= 4'h1 << i;
      repeat (4) @(posedge aclk);
      rd(A_ST, 32'h0001_0000 << i);
    end
    {dcd_pin, ri_pin, dsr_pin, cts_pin} <= 4'h0;
    repeat (4) @(posedge aclk);
    rd(8'h10, 32'h0000_0000, SLV);
    wr(8'h14, 32'hffff_ffff, SLV);
    wr(A_ST, 32'hffff_fdff);
    rd(A_ST, 32'h0000_0000);
    wr(srx_pkg::ADDR_GAP, 32'h0000_0008, srx_pkg::RESP_OKAY, 4);
    wr(A_CT, 32'h0000_0004);
    for (int i = 1; i <= 5; i++) line.send(8'(i * 17));
    repeat (20) @(posedge aclk);
    rd(A_ST, 32'h0400_0000 | CLS);
    wr(A_ST, CLS);
    rd(A_ST, RDY);
    rd(A_DT, 32'h4433_2211);
    rd(A_ST, RDY | ONE);
    rd(A_DT, 32'h0000_0055);
    rd(A_ST, 32'h0000_0000);
    wr(A_CT, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      line.send(8'(k + 1));
      line.flag(k);
      // the head count still shows while closed, it is just not trusted
      rd(A_ST, errs[k] | CLS | ONE);
      rd(A_DT, 32'h0000_0000);
      wr(A_ST, CLS);
      rd(A_ST, RDY | ONE);
      rd(A_DT, 32'(k + 1));
    end
    // one word past the 8-word fifo
    for (int i = 0; i < 36; i++) line.send(8'(i));
    rd(A_ST, 32'h0000_1000 | CLS);
    wr(A_ST, CLS);
    for (int j = 0; j < 8; j++)
      rd(A_DT, {8'(4*j+3), 8'(4*j+2), 8'(4*j+1), 8'(4*j)});
    rd(A_ST, 32'h0000_0000);
    wr(A_CT, 32'h0000_0001);
    repeat (4) line.send(8'ha5);
    // the irq flop lands one edge after ready
    repeat (2) @(posedge aclk);
    chk({31'h0, rx_ready_irq}, 32'h0000_0001);
    wr(A_CT, 32'h0000_0003);
    repeat (2) @(posedge aclk);
    chk({31'h0, rx_ready_irq}, 32'h0000_0000);
    rd(A_DT, 32'ha5a5_a5a5);
    line.send(8'h3c);
    line.flag(2);
    repeat (3) @(posedge aclk);
    chk({16'h0, seen_desc}, 32'h0000_0002);
    rd(A_ST, RDY | ONE);
    rd(A_DT, 32'h0000_003c);
    wr(A_CT, 32'h0000_0006);
    line.send(8'h5a);
    repeat (20) @(posedge aclk);
    chk({16'h0, seen_desc}, 32'h0000_0400);
    rd(A_ST, RDY | ONE);
    rd(A_DT, 32'h0000_005a);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end
endmodule
bind srx_status srx_status_assertions chk_i (.*);
`default_nettype wire
